// [src/flash_burst_pkg.sv]
`default_nettype none

package flash_burst_pkg;

  // Register byte offsets on the software port.
  localparam logic [3:0]  CFG_OFFSET        = 4'h0;
  localparam logic [3:0]  STS_OFFSET        = 4'h4;
  localparam logic [15:0] CFG_RESET         = 16'h0041;

  // Burst read configuration field positions.
  localparam int          EDGE_BIT          = 6;
  localparam int          WRAP_BIT          = 3;
  localparam int          LEN_LSB           = 0;

  // Burst length codes.
  localparam logic [2:0]  LEN_4             = 3'h1;
  localparam logic [2:0]  LEN_8             = 3'h2;
  localparam logic [2:0]  LEN_16            = 3'h3;
  localparam logic [2:0]  LEN_CONT          = 3'h7;

  // Status register field positions.
  localparam int          STS_POWER_LSB     = 0;
  localparam int          STS_MODE_BIT      = 2;
  localparam int          STS_BURST_BIT     = 3;
  localparam int          STS_WAIT_BIT      = 4;

  // Status word returned on the data pins in read status mode.
  localparam int          STAT_READY_BIT    = 7;
  localparam int          STAT_SEQ_ERR_BIT  = 4;

  // Command codes.
  localparam logic [7:0]  CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0]  CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0]  CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0]  CMD_PROG_SETUP    = 8'h40;
  localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0]  CMD_ERASE_CONFIRM = 8'hD0;

  // Timing: the power save entry delay in nanoseconds and in clock cycles.
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          APS_TIME_NS       = 5000;
  localparam int          APS_CYCLES        = (APS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          APS_CNT_W         = $clog2(APS_CYCLES + 1);

  typedef enum logic [1:0] {PWR_STANDBY = 2'b00, PWR_ACTIVE = 2'b01, PWR_APS = 2'b10} power_state_e;
  typedef enum logic {RM_ARRAY = 1'b0, RM_STATUS = 1'b1} read_mode_e;
  typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_PROG = 2'b01, CS_ERASE = 2'b10} cmd_state_e;
  typedef enum logic [1:0] {BS_IDLE = 2'b00, BS_LATENCY = 2'b01, BS_DATA = 2'b10,
                            BS_ROW_WAIT = 2'b11} burst_state_e;

  // Low address bits that roll over in wrap mode; zero means linear.
  function automatic logic [3:0] burst_wrap_mask(input logic [2:0] code);
    unique case (code)
      LEN_4:   return 4'h3;
      LEN_8:   return 4'h7;
      LEN_16:  return 4'hF;
      default: return 4'h0;
    endcase
  endfunction : burst_wrap_mask

  // Words in a fixed burst; zero means continuous.
  function automatic logic [4:0] burst_words(input logic [2:0] code);
    return {1'b0, burst_wrap_mask(code)} + ((code == LEN_4) || (code == LEN_8) ||
           (code == LEN_16) ? 5'h01 : 5'h00);
  endfunction : burst_words

endpackage : flash_burst_pkg

`default_nettype wire

// [src/burst_addr_step.sv]
`timescale 1ns/1ps
`default_nettype none

module burst_addr_step
  import flash_burst_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [2:0]        length_code_in,
  input  wire logic              wrap_disable_in,
  output logic      [ADDR_W-1:0] next_addr_out,
  output logic                   row_cross_out,
  output logic                   space_end_out
);

  // Wrap mode rolls only the bits covered by the length; otherwise count up.
  wire logic [ADDR_W-1:0] linear    = ADDR_W'(addr_in + 1'b1);
  wire logic [ADDR_W-1:0] full_mask = {{(ADDR_W-4){1'b0}}, burst_wrap_mask(length_code_in)};
  wire logic              wrapping  = !wrap_disable_in && (full_mask != '0);

  // Next address, a crossing into a new 16-word row, and the last address.
  assign next_addr_out = wrapping ? ((addr_in & ~full_mask) | (linear & full_mask)) : linear;
  assign row_cross_out = !wrapping && (linear[3:0] == 4'h0);
  assign space_end_out = &addr_in;

endmodule : burst_addr_step

`default_nettype wire

// [src/flash_burst_ctrl.sv]
// Summary of operation
// - Chosen clock edge starts bursts, drives data, wait.
// - Wrap mode rolls inside aligned word group.
// - No-wrap mode gives consecutive increasing addresses.
// - Wait stalls the host until data valid.
// - Length field picks 4, 8, 16, continuous.
// - Continuous burst linear until address space end.
// - No array reads beyond the selected length.
// - Active while selected and out of reset.
// - Power save when selected, idle, address quiet.
// - Deselected in read mode means standby, outputs off.
// - Program or erase keeps device active until done.
// - Reset disables device, ignores all control inputs.
// - Command taken only with write and select low.
// - Array changes only after two-cycle sequence.
// - Latched command survives select and busy changes.
// - Reset or supply lockout restores read array.
// - After program or erase, stay in status mode.
// - Misaligned linear burst waits once at row crossing.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module flash_burst_ctrl
  import flash_burst_pkg::*;
#(
  parameter int ADDR_W        = 16,
  parameter int DATA_W        = 16,
  parameter int FIRST_LATENCY = 4
)(
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  input  wire logic              link_clk_in,
  input  wire logic              ce_n_in,
  input  wire logic              we_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              adv_n_in,
  input  wire logic              lockout_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_out,
  output logic                   wait_out,
  output logic      [ADDR_W-1:0] array_addr_out,
  output logic                   array_rd_out,
  input  wire logic [DATA_W-1:0] array_data_in,
  output logic                   prog_start_out,
  output logic                   erase_start_out,
  output logic      [ADDR_W-1:0] op_addr_out,
  output logic      [DATA_W-1:0] op_data_out,
  input  wire logic              wsm_busy_in,
  output logic      [1:0]        power_state_out,
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [15:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [15:0]       reg_rdata_out
);

  localparam int               PW        = 6 + ADDR_W + DATA_W;
  localparam logic [PW-1:0]    PIN_IDLE  = {4'hF, {(PW-4){1'b0}}};
  localparam logic [3:0]       LAT_LOAD  = 4'(FIRST_LATENCY - 1);
  localparam logic [3:0]       ROW_LOAD  = 4'((FIRST_LATENCY > 2) ? FIRST_LATENCY - 2 : 0);

  logic         [PW-1:0]     pins_meta;
  logic         [PW-1:0]     pins_q;
  logic         [PW-1:0]     pins_prev;
  logic         [15:0]       burst_read_config;
  power_state_e              power_state;
  power_state_e              next_power;
  logic         [APS_CNT_W-1:0] aps_count;
  read_mode_e                read_mode;
  cmd_state_e                cmd_state;
  logic                      seq_err;
  burst_state_e              bstate;
  logic         [ADDR_W-1:0] burst_addr;
  logic         [3:0]        lat_cnt;
  logic         [4:0]        beat;
  logic                      start_misaligned;
  logic                      row_done;
  logic         [DATA_W-1:0] status_word;
  logic         [15:0]       sts_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: every pin passes two flops before any logic sees it.
  wire logic [PW-1:0] pins_raw = {ce_n_in, we_n_in, oe_n_in, adv_n_in, link_clk_in,
                                  lockout_in, addr_in, dq_in};

  // Two-stage capture plus one history stage for edge detection.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pins_meta <= PIN_IDLE;
      pins_q    <= PIN_IDLE;
      pins_prev <= PIN_IDLE;
    end
    else
    begin
      pins_meta <= pins_raw;
      pins_q    <= pins_meta;
      pins_prev <= pins_q;
    end
  end

  // Decoded pin levels and edges.
  wire logic              ce_low     = !pins_q[PW-1];
  wire logic              we_n_q     = pins_q[PW-2];
  wire logic              oe_low     = !pins_q[PW-3];
  wire logic              adv_low    = !pins_q[PW-4];
  wire logic              lclk_rise  = pins_q[PW-5] && !pins_prev[PW-5];
  wire logic              lclk_fall  = !pins_q[PW-5] && pins_prev[PW-5];
  wire logic              lockout    = pins_q[PW-6];
  wire logic [ADDR_W-1:0] addr_q     = pins_q[ADDR_W+DATA_W-1:DATA_W];
  wire logic [DATA_W-1:0] dq_q       = pins_q[DATA_W-1:0];
  wire logic              we_rise    = we_n_q && !pins_prev[PW-2];
  wire logic              addr_moved = addr_q != pins_prev[ADDR_W+DATA_W-1:DATA_W];

  //////////////////////////////////////////////////////////////////////////////
  // Configuration decode.
  wire logic [2:0] len_code    = burst_read_config[LEN_LSB+2:LEN_LSB];
  wire logic       wrap_dis    = burst_read_config[WRAP_BIT];
  wire logic       sel_edge    = burst_read_config[EDGE_BIT] ? lclk_rise : lclk_fall;
  wire logic [4:0] words       = burst_words(len_code);
  wire logic       linear_mode = wrap_dis || (len_code == LEN_CONT);

  // Software register port; reads answer one cycle later, zero when idle.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      burst_read_config <= CFG_RESET;
      reg_rdata_out     <= 16'h0000;
    end
    else
    begin
      if (reg_wr_in && (reg_addr_in == CFG_OFFSET))
        burst_read_config <= reg_wdata_in;
      reg_rdata_out <= !reg_rd_in ? 16'h0000 :
                       (reg_addr_in == CFG_OFFSET) ? burst_read_config :
                       (reg_addr_in == STS_OFFSET) ? sts_reg : 16'h0000;
    end
  end

  // Status words for software and for the data pins.
  always_comb
  begin
    sts_reg                                    = 16'h0000;
    sts_reg[STS_POWER_LSB+1:STS_POWER_LSB]     = power_state;
    sts_reg[STS_MODE_BIT]                      = read_mode;
    sts_reg[STS_BURST_BIT]                     = bstate != BS_IDLE;
    sts_reg[STS_WAIT_BIT]                      = wait_out;
    status_word                                = '0;
    status_word[STAT_READY_BIT]                = !wsm_busy_in;
    status_word[STAT_SEQ_ERR_BIT]              = seq_err;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command interface: writes are taken at the end of a select and write cycle.
  wire logic cmd_write = we_rise && ce_low;
  wire logic [7:0] cmd = dq_q[7:0];

  // Mode changes only by accepted commands or lockout; select and busy never touch it.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      read_mode       <= RM_ARRAY;
      cmd_state       <= CS_IDLE;
      seq_err         <= 1'b0;
      prog_start_out  <= 1'b0;
      erase_start_out <= 1'b0;
      op_addr_out     <= '0;
      op_data_out     <= '0;
    end
    else
    begin
      prog_start_out  <= 1'b0;
      erase_start_out <= 1'b0;
      if (lockout)
      begin
        read_mode <= RM_ARRAY;
        cmd_state <= CS_IDLE;
      end
      else if (cmd_write)
      begin
        unique case (cmd_state)
          CS_IDLE:
          begin
            if (cmd == CMD_READ_ARRAY)
              read_mode <= RM_ARRAY;
            else if (cmd == CMD_READ_STATUS)
              read_mode <= RM_STATUS;
            else if (cmd == CMD_CLEAR_STATUS)
              seq_err <= 1'b0;
            else if (cmd == CMD_PROG_SETUP)
              cmd_state <= CS_PROG;
            else if (cmd == CMD_ERASE_SETUP)
              cmd_state <= CS_ERASE;
          end
          CS_PROG:
          begin
            prog_start_out <= 1'b1;
            op_addr_out    <= addr_q;
            op_data_out    <= dq_q;
            read_mode      <= RM_STATUS;
            cmd_state      <= CS_IDLE;
          end
          default:
          begin
            erase_start_out <= cmd == CMD_ERASE_CONFIRM;
            seq_err         <= seq_err || (cmd != CMD_ERASE_CONFIRM);
            op_addr_out     <= addr_q;
            read_mode       <= RM_STATUS;
            cmd_state       <= CS_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state: busy keeps it active, idle time with a quiet bus saves power.
  wire logic aps_ready = aps_count == APS_CNT_W'(APS_CYCLES);
  wire logic aps_hold  = ce_low && !wsm_busy_in && (bstate == BS_IDLE) && !addr_moved;
  assign next_power = !(ce_low || wsm_busy_in) ? PWR_STANDBY :
                      (aps_hold && aps_ready) ? PWR_APS : PWR_ACTIVE;

  // Idle timer and state register; reset holds the device disabled.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      power_state <= PWR_STANDBY;
      aps_count   <= '0;
    end
    else
    begin
      power_state <= next_power;
      aps_count   <= !aps_hold ? '0 : aps_ready ? aps_count : APS_CNT_W'(aps_count + 1'b1);
    end
  end

  assign power_state_out = power_state;

  //////////////////////////////////////////////////////////////////////////////
  // Burst engine: state moves on the selected link clock edge; deselect returns it to idle at once.
  wire logic [ADDR_W-1:0] next_addr;
  wire logic              row_cross;
  wire logic              space_end;

  burst_addr_step #(.ADDR_W(ADDR_W)) u_step (
    .addr_in         (burst_addr),
    .length_code_in  (len_code),
    .wrap_disable_in (wrap_dis),
    .next_addr_out   (next_addr),
    .row_cross_out   (row_cross),
    .space_end_out   (space_end)
  );

  wire logic burst_start = sel_edge && ce_low && adv_low && we_n_q && !lockout &&
                           (read_mode == RM_ARRAY);
  wire logic deliver     = sel_edge && ce_low && (bstate == BS_DATA) && !burst_start;
  wire logic is_last     = (words != 5'h00) && (beat == 5'(words - 5'h01));
  wire logic go_row_wait = linear_mode && start_misaligned && !row_done && row_cross;

  // Latency, delivery and the one-time row crossing delay.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bstate           <= BS_IDLE;
      burst_addr       <= '0;
      lat_cnt          <= 4'h0;
      beat             <= 5'h00;
      start_misaligned <= 1'b0;
      row_done         <= 1'b0;
    end
    else if (!ce_low)
      bstate <= BS_IDLE;
    else if (burst_start)
    begin
      bstate           <= BS_LATENCY;
      burst_addr       <= addr_q;
      lat_cnt          <= LAT_LOAD;
      beat             <= 5'h00;
      start_misaligned <= addr_q[1:0] != 2'b00;
      row_done         <= 1'b0;
    end
    else if (sel_edge)
    begin
      unique case (bstate)
        BS_IDLE: bstate <= BS_IDLE;
        BS_LATENCY, BS_ROW_WAIT:
        begin
          bstate  <= (lat_cnt == 4'h0) ? BS_DATA : bstate;
          lat_cnt <= (lat_cnt == 4'h0) ? 4'h0 : 4'(lat_cnt - 1'b1);
        end
        BS_DATA:
        begin
          burst_addr <= next_addr;
          beat       <= 5'(beat + 1'b1);
          if (is_last || (space_end && linear_mode))
            bstate <= BS_IDLE;
          else if (go_row_wait)
          begin
            bstate   <= BS_ROW_WAIT;
            lat_cnt  <= ROW_LOAD;
            row_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // Array fetch only for a word being handed out: no lookahead reads.
  assign array_rd_out   = deliver;
  assign array_addr_out = burst_addr;
  assign wait_out       = (bstate == BS_LATENCY) || (bstate == BS_ROW_WAIT);
  assign dq_oe_out      = ce_low && oe_low;

  // Output data register: burst words on the chosen edge, else status.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      dq_out <= '0;
    else if (deliver)
      dq_out <= array_data_in;
    else if ((read_mode == RM_STATUS) && ce_low && oe_low)
      dq_out <= status_word;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_start;
    burst_start;
  endsequence
  sequence s_latency;
    wait_out && (bstate == BS_LATENCY);
  endsequence

  a_start_wait: assert property (s_start |=> s_latency)
    else $error("Wait not raised after burst start");
  a_edge_data: assert property ($changed(dq_out) && $past(read_mode) == RM_ARRAY
    |-> $past(sel_edge))
    else $error("Data changed off the selected edge");
  a_wrap_group: assert property (deliver && !wrap_dis && len_code == LEN_4
    |=> burst_addr[ADDR_W-1:2] == $past(burst_addr[ADDR_W-1:2]))
    else $error("Wrap burst left its word group");
  a_nowrap_step: assert property (deliver && wrap_dis && !space_end
    |=> burst_addr == ADDR_W'($past(burst_addr) + 1'b1))
    else $error("No-wrap burst did not step by one");
  a_len_stop: assert property (deliver && is_last |=> bstate == BS_IDLE ##1 !array_rd_out)
    else $error("Burst ran past its length");
  a_busy_active: assert property (wsm_busy_in |=> power_state == PWR_ACTIVE)
    else $error("Busy device left active state");
  a_standby_entry: assert property (!ce_low && !wsm_busy_in |-> !dq_oe_out
    ##1 power_state == PWR_STANDBY)
    else $error("Deselected device not in standby");
  a_aps_cause: assert property (power_state == PWR_APS |-> $past(ce_low) && $past(aps_ready))
    else $error("Power save without idle select");
  a_two_step: assert property (prog_start_out |-> $past(cmd_state) == CS_PROG)
    else $error("Program without setup cycle");
  a_mode_hold: assert property ($fell(wsm_busy_in) && !cmd_write && !lockout
    |=> $stable(read_mode))
    else $error("Read mode changed without command");

endmodule : flash_burst_ctrl

`default_nettype wire

// [verification/host_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host memory controller: command writes, burst starts and a gated burst clock.
module host_ctrl_model (
  input  wire logic        clk_in,
  output logic             link_clk_out,
  output logic             ce_n_out,
  output logic             we_n_out,
  output logic             oe_n_out,
  output logic             adv_n_out,
  output logic      [15:0] addr_out,
  output logic      [15:0] dq_out
);
  logic run;

  // Idle pins: deselected, no write, no output enable.
  initial
  begin
    {run, link_clk_out, ce_n_out, we_n_out, oe_n_out, adv_n_out} = 6'b001111;
    addr_out = 16'h0000;
    dq_out   = 16'h0000;
  end

  // The burst clock stands still outside frames, off phase to the system clock.
  initial
  begin
    #13;
    forever #80 if (run) link_clk_out = ~link_clk_out;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold

  // A command write has both selects low; the word is taken as write enable rises.
  task automatic write_cmd(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    ce_n_out <= 1'b0;
    we_n_out <= 1'b0;
    addr_out <= a;
    dq_out   <= d;
    hold(4);
    we_n_out <= 1'b1;
    hold(4);
    ce_n_out <= 1'b1;
    dq_out   <= ~d;
  endtask : write_cmd

  // Address valid is held over one edge of each polarity, so either edge choice sees it.
  task automatic start_burst(input logic [15:0] a);
    @(posedge clk_in);
    ce_n_out  <= 1'b0;
    oe_n_out  <= 1'b0;
    adv_n_out <= 1'b0;
    addr_out  <= a;
    hold(3);
    run = 1'b1;
    repeat (2) @(link_clk_out);
    hold(4);
    adv_n_out <= 1'b1;
  endtask : start_burst

  task automatic end_burst();
    run = 1'b0;
    hold(2);
    ce_n_out  <= 1'b1;
    oe_n_out  <= 1'b1;
  endtask : end_burst

  task automatic pins(input logic ce, input logic oe);
    @(posedge clk_in);
    ce_n_out <= ce;
    oe_n_out <= oe;
  endtask : pins
endmodule : host_ctrl_model
`default_nettype wire

// [verification/test_burst_read_config_power_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_burst_read_config_power_ctrl
  import flash_burst_pkg::*;
();
  logic             clock_in, rst_n_in, wsm_busy_in, lockout_in, reg_wr_in, reg_rd_in;
  wire logic        link_clk, ce_n, we_n, oe_n, adv_n;
  wire logic [15:0] addr, dq_pins, array_data;
  logic      [15:0] dq_out, array_addr_out, op_addr_out, op_data_out, reg_rdata_out;
  logic             dq_oe_out, wait_out, array_rd_out, prog_start_out, erase_start_out;
  logic      [1:0]  power_state_out;
  logic      [3:0]  reg_addr_in;
  logic      [15:0] reg_wdata_in, word_exp, d;
  logic             rd_d, word_d, wait_d;
  logic      [15:0] reg_q[$], addr_q[$], op_q[$];
  int               n_mismatch, n_tests, n_wait;

  // The array answers each address with a fixed pattern of it.
  assign array_data = array_addr_out ^ 16'h5A5A;

  flash_burst_ctrl #(.FIRST_LATENCY(2)) dut (
    .clock_in, .rst_n_in, .link_clk_in(link_clk), .ce_n_in(ce_n), .we_n_in(we_n),
    .oe_n_in(oe_n), .adv_n_in(adv_n), .lockout_in, .addr_in(addr), .dq_in(dq_pins),
    .dq_out, .dq_oe_out, .wait_out, .array_addr_out, .array_rd_out,
    .array_data_in(array_data), .prog_start_out, .erase_start_out, .op_addr_out,
    .op_data_out, .wsm_busy_in, .power_state_out, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out);

  host_ctrl_model m (
    .clk_in(clock_in), .link_clk_out(link_clk), .ce_n_out(ce_n), .we_n_out(we_n),
    .oe_n_out(oe_n), .adv_n_out(adv_n), .addr_out(addr), .dq_out(dq_pins));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] pop(ref logic [15:0] q[$]);
    if (q.size() == 0)
      return 16'hxxxx;
    return q.pop_front();
  endfunction : pop

  function automatic logic [15:0] sts(input logic md, input logic [1:0] p);
    return {13'h0000, md, p};
  endfunction : sts

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
  endtask : hold

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    reg_q.push_back(e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
  endtask : reg_rd

  task automatic exp_op(input logic er, input logic [15:0] a, input logic [15:0] v);
    op_q.push_back(a);
    if (!er)
      op_q.push_back(v);
    op_q.push_back({15'h0000, er});
  endtask : exp_op

  // One burst frame; fixed bursts run on to show that no further word is read.
  task automatic burst(input logic [15:0] cfg, input logic [15:0] a, input int n,
                       input logic x);
    logic [15:0] w;
    logic [15:0] nw;
    w = cfg[3] ? 16'hFFFF : cfg[2:0] == LEN_4 ? 16'h0003 : cfg[2:0] == LEN_8 ?
        16'h0007 : cfg[2:0] == LEN_16 ? 16'h000F : 16'hFFFF;
    // A misaligned linear burst that crosses a 16-word row waits a second time.
    nw = ((cfg[3] || cfg[2:0] == LEN_CONT) && a[1:0] != 2'b00 && a[3:0] + n > 16) ?
         16'h0002 : 16'h0001;
    reg_wr(CFG_OFFSET, cfg);
    reg_rd(CFG_OFFSET, cfg);
    for (int i = 0; i < n; i++)
      addr_q.push_back((a & ~w) | ((a + 16'(i)) & w));
    n_wait = 0;
    m.start_burst(a);
    check({15'h0000, dq_oe_out}, 16'h0001);
    for (int i = 0; i < 4000 && addr_q.size() != 0; i++)
      hold(1);
    if (x)
      hold(48);
    m.end_burst();
    check(16'(addr_q.size()), 16'h0000);
    check(16'(n_wait), nw);
  endtask : burst

  ////////////////////////////////////////////////////////////////////////
  // Monitor: each answer at the ports is paired with the oldest note.
  always @(posedge clock_in)
  begin
    rd_d   <= reg_rd_in;
    word_d <= array_rd_out;
    wait_d <= wait_out;
    if (wait_out === 1'b1 && wait_d !== 1'b1)
      n_wait <= n_wait + 1;
    if (rd_d)
      check(reg_rdata_out, pop(reg_q));
    if (word_d)
      check(dq_out, word_exp);
    if (array_rd_out === 1'b1)
    begin
      word_exp <= addr_q[0] ^ 16'h5A5A;
      check(array_addr_out, pop(addr_q));
    end
    if (prog_start_out === 1'b1 || erase_start_out === 1'b1)
    begin
      check(op_addr_out, pop(op_q));
      if (prog_start_out === 1'b1)
        check(op_data_out, pop(op_q));
      check({15'h0000, erase_start_out}, pop(op_q));
    end
  end

  // The clock toggles every half period.
  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    {rst_n_in, wsm_busy_in, lockout_in, reg_wr_in, reg_rd_in} = 5'b00000;
    {rd_d, word_d, wait_d} = 3'b000;
    reg_addr_in  = 4'h0;
    reg_wdata_in = 16'h0000;
    word_exp     = 16'h0000;
    n_mismatch   = 0;
    n_tests      = 0;
    void'($urandom(74));
    d = 16'($urandom);
    hold(6);
    rst_n_in <= 1'b1;
    hold(2);
    reg_rd(CFG_OFFSET, CFG_RESET);
    reg_wr(STS_OFFSET, 16'hFFFF);
    reg_wr(4'h8, 16'h1234);
    reg_rd(STS_OFFSET, sts(RM_ARRAY, PWR_STANDBY));
    reg_rd(4'h8, 16'h0000);
    reg_rd(CFG_OFFSET, CFG_RESET);
    burst(16'h0041, 16'h0001, 4, 1'b1);
    burst(16'h0049, 16'h0003, 4, 1'b1);
    burst(16'h0001, 16'h0003, 4, 1'b1);
    burst(16'h0042, d & 16'h00FF, 8, 1'b1);
    burst(16'h0043, 16'h000E, 16, 1'b1);
    burst(16'h004B, 16'h000E, 16, 1'b1);
    burst(16'h0047, 16'h0020, 20, 1'b0);
    burst(16'h0047, 16'hFFFC, 4, 1'b1);
    m.pins(1'b0, 1'b0);
    hold(20);
    check(16'(power_state_out), 16'(PWR_ACTIVE));
    hold(250);
    check(16'(power_state_out), 16'(PWR_APS));
    check({15'h0000, dq_oe_out}, 16'h0001);
    m.pins(1'b1, 1'b0);
    hold(5);
    check(16'(power_state_out), 16'(PWR_STANDBY));
    check({15'h0000, dq_oe_out}, 16'h0000);
    m.pins(1'b1, 1'b1);
    m.write_cmd(16'h0123, 16'(CMD_PROG_SETUP));
    hold(10);
    exp_op(1'b0, 16'h0123, d);
    m.write_cmd(16'h0123, d);
    wsm_busy_in <= 1'b1;
    hold(5);
    check(16'(power_state_out), 16'(PWR_ACTIVE));
    wsm_busy_in <= 1'b0;
    hold(5);
    check(16'(power_state_out), 16'(PWR_STANDBY));
    reg_rd(STS_OFFSET, sts(RM_STATUS, PWR_STANDBY));
    m.write_cmd(16'h0200, 16'(CMD_ERASE_SETUP));
    m.write_cmd(16'h0200, 16'h0055);
    m.write_cmd(16'h0200, 16'(CMD_ERASE_SETUP));
    exp_op(1'b1, 16'h0200, 16'h0000);
    m.write_cmd(16'h0200, 16'(CMD_ERASE_CONFIRM));
    m.start_burst(16'h0010);
    check(dq_out, 16'h0090);
    hold(80);
    m.end_burst();
    m.write_cmd(16'h0000, 16'(CMD_CLEAR_STATUS));
    m.pins(1'b0, 1'b0);
    hold(5);
    check(dq_out, 16'h0080);
    m.pins(1'b1, 1'b1);
    m.write_cmd(16'h0000, 16'(CMD_READ_ARRAY));
    hold(2);
    reg_rd(STS_OFFSET, sts(RM_ARRAY, PWR_STANDBY));
    reg_wr(CFG_OFFSET, 16'h0049);
    m.write_cmd(16'h0000, 16'(CMD_READ_STATUS));
    rst_n_in <= 1'b0;
    m.write_cmd(16'h0300, 16'(CMD_PROG_SETUP));
    m.write_cmd(16'h0300, 16'h00AA);
    rst_n_in <= 1'b1;
    hold(2);
    reg_rd(CFG_OFFSET, CFG_RESET);
    reg_rd(STS_OFFSET, sts(RM_ARRAY, PWR_STANDBY));
    m.write_cmd(16'h0000, 16'(CMD_READ_STATUS));
    hold(2);
    reg_rd(STS_OFFSET, sts(RM_STATUS, PWR_STANDBY));
    lockout_in <= 1'b1;
    hold(5);
    reg_rd(STS_OFFSET, sts(RM_ARRAY, PWR_STANDBY));
    lockout_in <= 1'b0;
    hold(4);
    print_verdict();
  end
endmodule : test_burst_read_config_power_ctrl
`default_nettype wire
